// ---- radio_link_setup_regs_tb.sv ----
/*
 * Self-checking bench for rlsr_regs with an SPI host model.
 * Assumes a 250 MHz clock and a shortened retransmit step.
 */
`timescale 1ns/1ns
module radio_link_setup_regs_tb;
	import rlsr_pkg::*;
	localparam int STEP = 4;
	localparam logic [7:0] RST_V [5] = '{8'h03, 8'h03, 8'h03, 8'h02, 8'h08};
	localparam logic [7:0] MSK [5]   = '{8'h03, 8'h03, 8'hFF, 8'h7F, 8'hB8};
	logic       clk, rst_n, op_start, tx_new, tx_end, ack_ok, rx_pipe_valid;
	logic [2:0] rx_pipe_num, width_bytes;
	logic [4:0] addr_byte_mask;
	logic [6:0] radio_channel, prev_ch;
	logic       sck, csn_n, mosi, miso_o, miso_oe, cc, fl, rt_start, flag, blocked, acc;
	logic [3:0] retry_count;
	logic [7:0] st, d, v [5];
	rlsr_rate_t data_rate;
	int         error_cnt, n_compared, cyc, n, seed_v;
	wire        miso_w = miso_oe ? miso_o : ~miso_o;

	rlsr_regs #(.STEP_CYCLES(STEP)) u_dut (.clk(clk), .rst_n(rst_n), .spi_sck(sck),
		.spi_csn_n(csn_n), .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
		.op_start(op_start), .tx_new(tx_new), .tx_end(tx_end), .ack_ok(ack_ok),
		.rx_pipe_valid(rx_pipe_valid), .rx_pipe_num(rx_pipe_num), .width_bytes(width_bytes),
		.addr_byte_mask(addr_byte_mask), .radio_channel(radio_channel), .data_rate(data_rate),
		.continuous_carrier(cc), .force_lock(fl), .retransmit_start(rt_start),
		.retry_count(retry_count), .retry_exhausted_flag(flag), .link_blocked(blocked),
		.rx_pipe_accept(acc));
	rlsr_host u_host (.clk(clk), .sck(sck), .csn_n(csn_n), .mosi(mosi), .miso(miso_w));

	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] x);
		logic [7:0] r;
		u_host.frame({CMD_WRITE, a}, x, st, r);
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] x);
		u_host.frame({CMD_READ, a}, 8'h00, st, x);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic wait_ev(input int lim, output int k);
		k = 0;
		while (k < lim && rt_start !== 1'b1 && flag !== 1'b1) begin
			@(negedge clk);
			k++;
		end
	endtask
	function automatic logic [7:0] exp_mask(input logic [1:0] c);
		return (c == 2'h0) ? 8'h00 : (8'h1F >> (2'h3 - c));
	endfunction
	function automatic logic [7:0] in_win(input int k, input int t);
		return {7'h0, (k == t || k == t + 1)};
	endfunction
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{clk, rst_n, op_start, tx_new, tx_end, ack_ok, rx_pipe_valid} = '0;
		rx_pipe_num = 3'h0;
		seed_v = $urandom(32'hF91B7ED9);
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk({5'h0, width_bytes}, 8'h05);
		chk({3'h0, addr_byte_mask}, 8'h1F);
		chk({1'b0, radio_channel}, 8'h02);
		chk({6'h0, data_rate}, 8'h01);
		chk({6'h0, cc, fl}, 8'h00);
		for (int i = 0; i < 5; i++) begin
			rd(REG_PIPE_EN + 5'(i), d);
			chk(d, RST_V[i]);
			chk(st, 8'h00);
		end
		$display("test reset values done");
		prev_ch = CH_RST;
		for (int r = 0; r < 8; r++) begin
			for (int i = 0; i < 5; i++) v[i] = 8'($urandom);
			if (v[1][1:0] == 2'h0) v[1][0] = 1'b1;
			if (v[4][5]) v[4][3] = 1'b0;
			for (int i = 0; i < 5; i++) wr(REG_PIPE_EN + 5'(i), v[i]);
			chk({6'h0, cc, fl}, {6'h0, v[4][7], v[4][4]});
			chk({1'b0, radio_channel}, {1'b0, prev_ch});
			for (int i = 0; i < 5; i++) begin
				rd(REG_PIPE_EN + 5'(i), d);
				chk(d, v[i] & MSK[i]);
			end
			pulse(op_start);
			@(negedge clk);
			prev_ch = v[3][6:0];
			chk({5'h0, width_bytes}, {6'h0, v[1][1:0]} + 8'h02);
			chk({3'h0, addr_byte_mask}, exp_mask(v[1][1:0]));
			chk({1'b0, radio_channel}, {1'b0, prev_ch});
			chk({6'h0, data_rate}, {6'h0, v[4][5], v[4][3]});
		end
		wr(5'h1F, 8'hFF);
		rd(5'h1F, d);
		chk(d, 8'h00);
		$display("test register access done");
		wr(REG_RETR, 8'h12);
		pulse(op_start);
		pulse(tx_new);
		for (int k = 0; k < 3; k++) begin
			pulse(tx_end);
			wait_ev(200, n);
			chk(in_win(n, 2 * STEP), 8'h01);
			chk({6'h0, rt_start, flag}, (k < 2) ? 8'h02 : 8'h01);
			chk({4'h0, retry_count}, 8'(k < 2 ? k + 1 : 2));
		end
		rd(REG_STATUS, d);
		chk(d, 8'h10);
		chk(st, 8'h10);
		chk({7'h0, blocked}, 8'h01);
		pulse(tx_end);
		wr(REG_STATUS, 8'h10);
		chk({7'h0, flag}, 8'h00);
		pulse(tx_new);
		pulse(tx_end);
		pulse(ack_ok);
		wait_ev(20, n);
		chk(8'(n), 8'h14);
		chk({4'h0, retry_count}, 8'h00);
		wr(REG_RETR, 8'h00);
		pulse(op_start);
		pulse(tx_new);
		pulse(tx_end);
		wait_ev(200, n);
		chk(in_win(n, STEP), 8'h01);
		chk({6'h0, rt_start, flag}, 8'h01);
		wr(REG_STATUS, 8'h10);
		$display("test retransmit done");
		for (int e = 0; e < 4; e++) begin
			wr(REG_PIPE_EN, 8'(e));
			for (int p = 0; p < 8; p++) begin
				rx_pipe_num = 3'(p);
				pulse(rx_pipe_valid);
				chk({7'h0, acc}, {7'h0, p < 2 && e[p % 2] == 1'b1});
			end
		end
		$display("test pipe enables done");
		report_and_stop();
	end
endmodule // radio_link_setup_regs_tb

// ---- rlsr_host.sv ----
/*
 * SPI mode 0 host model for the radio link setup register bank.
 * Assumes clk is the core clock; pins change at its falling edge.
 */
`timescale 1ns/1ns
module rlsr_host (
	// Clock
	input  wire logic clk,
	// SPI pins
	output logic      sck,
	output logic      csn_n,
	output logic      mosi,
	input  wire logic miso
);
	localparam int HALF = 10;
	initial begin
		sck = 1'b0;
		csn_n = 1'b1;
		mosi = 1'b0;
	end
	// ------------------------------------------------------------
	// One frame: command byte, one data byte, MSB first
	// ------------------------------------------------------------
	task automatic frame(input logic [7:0] cmd, input logic [7:0] dat,
		output logic [7:0] st, output logic [7:0] rd);
		logic [15:0] sh;
		logic [15:0] got;
		sh = {cmd, dat};
		@(negedge clk);
		csn_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = sh[i];
			repeat (HALF) @(negedge clk);
			sck = 1'b1;
			got[i] = miso;
			repeat (HALF) @(negedge clk);
			sck = 1'b0;
		end
		repeat (HALF) @(negedge clk);
		csn_n = 1'b1;
		mosi = ~mosi;
		repeat (HALF) @(negedge clk);
		st = got[15:8];
		rd = got[7:0];
	endtask
endmodule // rlsr_host

// ---- rlsr_pkg.sv ----
/*
 * Shared constants and types for the radio link setup register bank:
 * register offsets, SPI command codes, field positions, reset values,
 * decode tables and timing. Assumes a 250 MHz core clock.
 */
package rlsr_pkg;
	// ------------------------------------------------------------
	// Register offsets and SPI commands
	// ------------------------------------------------------------
	localparam logic [4:0] REG_PIPE_EN   = 5'h02;
	localparam logic [4:0] REG_AW        = 5'h03;
	localparam logic [4:0] REG_RETR      = 5'h04;
	localparam logic [4:0] REG_CH        = 5'h05;
	localparam logic [4:0] REG_RF        = 5'h06;
	localparam logic [4:0] REG_STATUS    = 5'h07;
	localparam logic [2:0] CMD_READ      = 3'h0;
	localparam logic [2:0] CMD_WRITE     = 3'h1;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int         RETR_DLY_LSB  = 4;
	localparam int         RF_CW_BIT     = 7;
	localparam int         RF_LOW_BIT    = 5;
	localparam int         RF_LOCK_BIT   = 4;
	localparam int         RF_HIGH_BIT   = 3;
	localparam int         STAT_RT_BIT   = 4;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0] PIPE_EN_RST   = 2'h3;
	localparam logic [1:0] AW_RST        = 2'h3;
	localparam logic [3:0] DLY_RST       = 4'h0;
	localparam logic [3:0] LIM_RST       = 4'h3;
	localparam logic [6:0] CH_RST        = 7'h02;
	localparam logic       CW_RST        = 1'b0;
	localparam logic       LOW_RST       = 1'b0;
	localparam logic       LOCK_RST      = 1'b0;
	localparam logic       HIGH_RST      = 1'b1;
	// ------------------------------------------------------------
	// Address width decode
	// ------------------------------------------------------------
	localparam logic [1:0] AW_3B         = 2'h1;
	localparam logic [1:0] AW_4B         = 2'h2;
	localparam logic [1:0] AW_5B         = 2'h3;
	localparam logic [2:0] WIDTH_NONE    = 3'h0;
	localparam logic [2:0] WIDTH_3       = 3'h3;
	localparam logic [2:0] WIDTH_4       = 3'h4;
	localparam logic [2:0] WIDTH_5       = 3'h5;
	localparam logic [4:0] MASK_NONE     = 5'h00;
	localparam logic [4:0] MASK_3        = 5'h07;
	localparam logic [4:0] MASK_4        = 5'h0F;
	localparam logic [4:0] MASK_5        = 5'h1F;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         CLK_MHZ       = 250;
	localparam int         ARD_STEP_US   = 250;
	localparam int         ARD_STEP_CYCLES = ARD_STEP_US * CLK_MHZ;
	localparam int         DLY_W         = 20;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_1M   = 2'b00,
		RATE_2M   = 2'b01,
		RATE_250K = 2'b10
	} rlsr_rate_t;
	typedef enum logic {
		RT_IDLE = 1'b0,
		RT_WAIT = 1'b1
	} rlsr_rt_state_t;
	typedef enum logic {
		PH_CMD  = 1'b0,
		PH_DATA = 1'b1
	} rlsr_phase_t;
endpackage

// ---- rlsr_regs.sv ----
/*
 * Radio link setup register bank: SPI register access, address width,
 * retransmission timing and count, channel, radio setup and pipe enables.
 * Assumes core strobes arrive on clk and SPI pins are asynchronous.
 */
`timescale 1ns/1ns
// Function
// RL1: Width code 01/10/11 means 3/4/5 bytes; resets to 11; 00 is illegal.
// RL2: One address width setting serves every receive pipe and transmit.
// RL3: Narrower widths use the low bytes of each address register only.
// RL4: Retransmit delay runs from end of transmission; 250 us times code plus one.
// RL5: Retry count field limits retransmissions; zero disables; resets to three.
// RL6: Seven-bit channel field resets to two; bit seven reads zero.
// RL7: Rate pair low,high decodes 00 1M, 01 2M, 10 250k; high resets one.
// RL8: High rate bit ignored while low rate bit set; pair 11 unused.
// RL9: Continuous carrier output follows radio setup bit seven; resets low.
// RL10: Radio setup bit four forces synthesizer lock; test use only.
// RL11: Undefined and reserved bits read back as zero.
// RL12: All registers reached by SPI read and write transactions.
// RL13: Exhausted retries set a sticky flag blocking traffic until written one.
// RL14: New settings take effect at the next operation start; carrier, lock and pipe enables apply at once.
// RL15: Receive traffic accepted only on enabled pipes; pipes zero, one enabled.
module rlsr_regs
#(
	parameter int STEP_CYCLES = rlsr_pkg::ARD_STEP_CYCLES
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// SPI pins
	input  wire logic              spi_sck,
	input  wire logic              spi_csn_n,
	input  wire logic              spi_mosi,
	output logic                   spi_miso_o,
	output logic                   spi_miso_oe,
	// Core strobes
	input  wire logic              op_start,
	input  wire logic              tx_new,
	input  wire logic              tx_end,
	input  wire logic              ack_ok,
	input  wire logic              rx_pipe_valid,
	input  wire logic [2:0]        rx_pipe_num,
	// Active settings
	output logic [2:0]             width_bytes,
	output logic [4:0]             addr_byte_mask,
	output logic [6:0]             radio_channel,
	output rlsr_pkg::rlsr_rate_t   data_rate,
	output logic                   continuous_carrier,
	output logic                   force_lock,
	// Retransmit and receive status
	output logic                   retransmit_start,
	output logic [3:0]             retry_count,
	output logic                   retry_exhausted_flag,
	output logic                   link_blocked,
	output logic                   rx_pipe_accept
);
	import rlsr_pkg::*;

	// ------------------------------------------------------------
	// SPI shifter
	// ------------------------------------------------------------
	rlsr_spi_if spi ();
	rlsr_spi_slave u_spi (
		.clk     (clk),
		.rst_n   (rst_n),
		.sck_i   (spi_sck),
		.csn_n_i (spi_csn_n),
		.mosi_i  (spi_mosi),
		.miso_o  (spi_miso_o),
		.miso_oe (spi_miso_oe),
		.spi     (spi)
	);

	// ------------------------------------------------------------
	// Stored registers
	// ------------------------------------------------------------
	logic [1:0]      pipe_en_q;
	logic [1:0]      aw_q;
	logic [3:0]      dly_q;
	logic [3:0]      lim_q;
	logic [6:0]      ch_q;
	logic            cw_q;
	logic            low_q;
	logic            lock_q;
	logic            high_q;
	logic            flag_q;
	logic            flag_d;
	rlsr_phase_t     phase_q;
	logic [7:0]      cmd_q;
	logic [7:0]      rd_data_q;

	// ------------------------------------------------------------
	// Command decode and read mux
	// ------------------------------------------------------------
	wire        cmd_take = spi.rx_valid & spi.rx_first;
	wire        wr_en    = spi.rx_valid & ~spi.rx_first & (phase_q == PH_DATA) &
	                       (cmd_q[7:5] == CMD_WRITE); // see RL12
	wire  [4:0] wr_addr  = cmd_q[4:0];
	wire  [7:0] wr_data  = spi.rx_byte;
	wire  [4:0] rd_addr  = spi.rx_byte[4:0];
	wire        rd_cmd   = spi.rx_byte[7:5] == CMD_READ;
	wire  [7:0] rd_pipe  = {6'h00, pipe_en_q};             // see RL11
	wire  [7:0] rd_aw    = {6'h00, aw_q};                  // see RL11
	wire  [7:0] rd_retr  = {dly_q, lim_q};
	wire  [7:0] rd_ch    = {1'b0, ch_q};                   // see RL6
	wire  [7:0] rd_rf    = {cw_q, 1'b0, low_q, lock_q, high_q, 3'h0};
	wire  [7:0] rd_stat  = {3'h0, flag_q, 4'h0};
	wire  [7:0] rd_mux   = (rd_addr == REG_PIPE_EN) ? rd_pipe :
	                       (rd_addr == REG_AW)      ? rd_aw   :
	                       (rd_addr == REG_RETR)    ? rd_retr :
	                       (rd_addr == REG_CH)      ? rd_ch   :
	                       (rd_addr == REG_RF)      ? rd_rf   :
	                       (rd_addr == REG_STATUS)  ? rd_stat : 8'h00; // see RL11
	wire        stat_clr = wr_en & (wr_addr == REG_STATUS) & wr_data[STAT_RT_BIT];
	assign spi.tx_byte = (phase_q == PH_DATA) ? rd_data_q : rd_stat;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q   <= PH_CMD;
			cmd_q     <= 8'h00;
			rd_data_q <= 8'h00;
		end else if (!spi.cs_active) begin
			phase_q <= PH_CMD;
		end else if (cmd_take) begin
			phase_q   <= PH_DATA;
			cmd_q     <= spi.rx_byte;
			rd_data_q <= rd_cmd ? rd_mux : 8'h00; // see RL12
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pipe_en_q <= PIPE_EN_RST; // see RL15
			aw_q      <= AW_RST;      // see RL1
			dly_q     <= DLY_RST;     // see RL4
			lim_q     <= LIM_RST;     // see RL5
			ch_q      <= CH_RST;      // see RL6
			cw_q      <= CW_RST;      // see RL9
			low_q     <= LOW_RST;
			lock_q    <= LOCK_RST;    // see RL10
			high_q    <= HIGH_RST;    // see RL7
		end else if (wr_en) begin
			case (wr_addr)
				REG_PIPE_EN: pipe_en_q <= wr_data[1:0];
				REG_AW:      aw_q      <= wr_data[1:0];
				REG_RETR: begin
					dly_q <= wr_data[RETR_DLY_LSB +: 4];
					lim_q <= wr_data[3:0];
				end
				REG_CH:      ch_q      <= wr_data[6:0];
				REG_RF: begin
					cw_q   <= wr_data[RF_CW_BIT];
					low_q  <= wr_data[RF_LOW_BIT];
					lock_q <= wr_data[RF_LOCK_BIT];
					high_q <= wr_data[RF_HIGH_BIT];
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Setting decode and apply at operation start; carrier and lock follow at once
	// ------------------------------------------------------------
	wire  [2:0]       width_dec = (aw_q == AW_3B) ? WIDTH_3 :
	                              (aw_q == AW_4B) ? WIDTH_4 :
	                              (aw_q == AW_5B) ? WIDTH_5 : WIDTH_NONE; // see RL1
	wire  [4:0]       mask_dec  = (aw_q == AW_3B) ? MASK_3 :
	                              (aw_q == AW_4B) ? MASK_4 :
	                              (aw_q == AW_5B) ? MASK_5 : MASK_NONE;   // see RL3
	wire  rlsr_rate_t rate_dec  = low_q ? RATE_250K :
	                              (high_q ? RATE_2M : RATE_1M);         // see RL7 RL8
	logic [3:0]       act_dly_q;
	logic [3:0]       act_lim_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			width_bytes    <= WIDTH_5;
			addr_byte_mask <= MASK_5;
			radio_channel  <= CH_RST;
			data_rate      <= RATE_2M;
			act_dly_q      <= DLY_RST;
			act_lim_q      <= LIM_RST;
		end else if (op_start) begin
			width_bytes    <= width_dec; // see RL2 RL14
			addr_byte_mask <= mask_dec;  // see RL3
			radio_channel  <= ch_q;      // see RL14
			data_rate      <= rate_dec;  // see RL7
			act_dly_q      <= dly_q;
			act_lim_q      <= lim_q;
		end
	end
	assign continuous_carrier = cw_q;   // see RL9
	assign force_lock         = lock_q; // see RL10

	// ------------------------------------------------------------
	// Retransmit timer and retry counter
	// ------------------------------------------------------------
	rlsr_rt_state_t   rt_state_q;
	logic [DLY_W-1:0] wait_q;
	logic [3:0]       retry_q;
	logic             rt_pulse_q;
	wire  [31:0]      dly_full   = (32'(act_dly_q) + 32'h1) * 32'(STEP_CYCLES) - 32'h1;
	wire  [DLY_W-1:0] dly_target = dly_full[DLY_W-1:0]; // see RL4
	wire              expire     = (rt_state_q == RT_WAIT) & ~ack_ok & (wait_q == dly_target);
	wire              can_retry  = retry_q < act_lim_q; // see RL5
	wire              flag_set   = expire & ~can_retry; // see RL13
	assign flag_d = flag_set | (flag_q & ~stat_clr); // see RL13
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rt_state_q <= RT_IDLE;
			wait_q     <= '0;
			retry_q    <= 4'h0;
			rt_pulse_q <= 1'b0;
			flag_q     <= 1'b0;
		end else begin
			flag_q     <= flag_d;
			rt_pulse_q <= 1'b0;
			case (rt_state_q)
				RT_IDLE: begin
					wait_q <= '0;
					if (tx_new) begin
						retry_q <= 4'h0;
					end
					if (tx_end && !flag_q) begin
						rt_state_q <= RT_WAIT; // see RL4 RL13
					end
				end
				RT_WAIT: begin
					if (ack_ok) begin
						rt_state_q <= RT_IDLE;
					end else if (expire) begin
						rt_state_q <= RT_IDLE;
						if (can_retry) begin
							rt_pulse_q <= 1'b1; // see RL5
							retry_q    <= retry_q + 4'h1;
						end
					end else begin
						wait_q <= wait_q + DLY_W'(1);
					end
				end
				default: rt_state_q <= RT_IDLE;
			endcase
		end
	end

	assign retransmit_start     = rt_pulse_q;
	assign retry_count          = retry_q;
	assign retry_exhausted_flag = flag_q;
	assign link_blocked         = flag_q;

	// ------------------------------------------------------------
	// Receive pipe filter
	// ------------------------------------------------------------
	logic accept_q;
	wire  pipe_ok = rx_pipe_valid & (rx_pipe_num < 3'h2) & pipe_en_q[rx_pipe_num[0]];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			accept_q <= 1'b0;
		end else begin
			accept_q <= pipe_ok; // see RL15
		end
	end
	assign rx_pipe_accept = accept_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_exhaust;
		(rt_state_q == RT_WAIT) && !ack_ok && (wait_q == dly_target) && (retry_q >= act_lim_q);
	endsequence
	sequence s_rf_write;
		wr_en && (wr_addr == REG_RF);
	endsequence

	property p_width_decode;
		@(posedge clk) disable iff (!rst_n)
		(op_start && aw_q == AW_4B) |=> (width_bytes == 3'h4);
	endproperty
	a_width_decode: assert property (p_width_decode) else $error("width decode wrong"); // see RL1
	property p_width_shared;
		@(posedge clk) disable iff (!rst_n)
		$countones(addr_byte_mask) == 32'(width_bytes);
	endproperty
	a_width_shared: assert property (p_width_shared) else $error("mask and width differ"); // see RL2
	property p_lsb_mask;
		@(posedge clk) disable iff (!rst_n)
		(width_bytes == 3'h3) |-> (addr_byte_mask == 5'h07);
	endproperty
	a_lsb_mask: assert property (p_lsb_mask) else $error("low bytes not selected"); // see RL3
	property p_retx_at_expiry;
		@(posedge clk) disable iff (!rst_n)
		retransmit_start |-> $past(rt_state_q == RT_WAIT && wait_q == dly_target);
	endproperty
	a_retx_at_expiry: assert property (p_retx_at_expiry) else $error("early retransmit"); // see RL4
	property p_retry_limit;
		@(posedge clk) disable iff (!rst_n)
		retransmit_start |-> (retry_q != 4'h0) && (retry_q <= act_lim_q);
	endproperty
	a_retry_limit: assert property (p_retry_limit) else $error("retry over limit"); // see RL5
	property p_rsvd_zero;
		@(posedge clk) disable iff (!rst_n)
		(phase_q == PH_DATA && cmd_q[7:5] == CMD_READ && cmd_q[4:0] == REG_CH)
			|-> (rd_data_q[7] == 1'b0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one"); // see RL11
	property p_low_rate;
		@(posedge clk) disable iff (!rst_n)
		(op_start && low_q) |=> (data_rate == RATE_250K);
	endproperty
	a_low_rate: assert property (p_low_rate) else $error("low rate not chosen"); // see RL8
	property p_carrier;
		@(posedge clk) disable iff (!rst_n)
		s_rf_write |=> (continuous_carrier == $past(wr_data[RF_CW_BIT])) &&
			(force_lock == $past(wr_data[RF_LOCK_BIT]));
	endproperty
	a_carrier: assert property (p_carrier) else $error("radio setup bit not applied"); // see RL9
	property p_flag_set;
		@(posedge clk) disable iff (!rst_n)
		s_exhaust |=> retry_exhausted_flag && !retransmit_start;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("exhaust flag missing"); // see RL13
	property p_blocked;
		@(posedge clk) disable iff (!rst_n)
		(flag_q && rt_state_q == RT_IDLE) |=> (rt_state_q == RT_IDLE);
	endproperty
	a_blocked: assert property (p_blocked) else $error("traffic while blocked"); // see RL13
	property p_settings_hold;
		@(posedge clk) disable iff (!rst_n)
		!op_start |=> $stable(radio_channel) && $stable(width_bytes) && $stable(data_rate);
	endproperty
	a_settings_hold: assert property (p_settings_hold) else $error("setting moved mid op"); // see RL14
	property p_pipe;
		@(posedge clk) disable iff (!rst_n)
		rx_pipe_accept |-> $past(rx_pipe_valid && rx_pipe_num < 3'h2 && pipe_en_q[rx_pipe_num[0]]);
	endproperty
	a_pipe: assert property (p_pipe) else $error("disabled pipe accepted"); // see RL15
endmodule // rlsr_regs

// ---- rlsr_spi_if.sv ----
/*
 * Byte-level carrier between the SPI shifter and the register bank.
 * Assumes both ends sit on the same core clock.
 */
`timescale 1ns/1ns
interface rlsr_spi_if;
	logic [7:0] rx_byte;
	logic       rx_valid;
	logic       rx_first;
	logic       cs_active;
	logic [7:0] tx_byte;
	modport slave (output rx_byte, output rx_valid, output rx_first, output cs_active,
		input tx_byte);
	modport bank (input rx_byte, input rx_valid, input rx_first, input cs_active,
		output tx_byte);
endinterface

// ---- rlsr_spi_slave.sv ----
/*
 * SPI mode 0 slave shifter, oversampled on the core clock.
 * Assumes SCK high and low phases each last at least 8 core cycles.
 */
`timescale 1ns/1ns
module rlsr_spi_slave (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// SPI pins
	input  wire logic  sck_i,
	input  wire logic  csn_n_i,
	input  wire logic  mosi_i,
	output logic       miso_o,
	output logic       miso_oe,
	// Byte side
	rlsr_spi_if.slave  spi
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] sck_s_q;
	logic [2:0] csn_s_q;
	logic [1:0] mosi_s_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic [7:0] rx_byte_q;
	logic       rx_valid_q;
	logic       first_q;
	wire        sck_rise = sck_s_q[1] & ~sck_s_q[2];
	wire        sck_fall = ~sck_s_q[1] & sck_s_q[2];
	wire        cs_act   = ~csn_s_q[1];
	wire        cs_fall  = ~csn_s_q[1] & csn_s_q[2];
	wire  [7:0] sh_next  = {sh_q[6:0], mosi_s_q[1]};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_s_q  <= 3'h0;
			csn_s_q  <= 3'h7;
			mosi_s_q <= 2'h0;
		end else begin
			sck_s_q  <= {sck_s_q[1:0], sck_i};
			csn_s_q  <= {csn_s_q[1:0], csn_n_i};
			mosi_s_q <= {mosi_s_q[0], mosi_i};
		end
	end

	// ------------------------------------------------------------
	// Shift in and out
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_q      <= 3'h0;
			sh_q       <= 8'h00;
			tx_q       <= 8'h00;
			rx_byte_q  <= 8'h00;
			rx_valid_q <= 1'b0;
			first_q    <= 1'b1;
		end else begin
			rx_valid_q <= 1'b0;
			if (!cs_act) begin
				bit_q   <= 3'h0;
				first_q <= 1'b1;
			end else if (sck_rise) begin
				sh_q  <= sh_next;
				bit_q <= bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					rx_valid_q <= 1'b1;
					rx_byte_q  <= sh_next;
				end
			end
			if (rx_valid_q && cs_act) begin
				first_q <= 1'b0;
			end
			if (cs_fall) begin
				tx_q <= spi.tx_byte;
			end else if (sck_fall && cs_act) begin
				tx_q <= (bit_q == 3'h0) ? spi.tx_byte : {tx_q[6:0], 1'b0};
			end
		end
	end

	assign miso_o        = tx_q[7];
	assign miso_oe       = cs_act;
	assign spi.rx_byte   = rx_byte_q;
	assign spi.rx_valid  = rx_valid_q;
	assign spi.rx_first  = first_q;
	assign spi.cs_active = cs_act;
endmodule // rlsr_spi_slave
